//--- design/usfw_top.sv
// Start-of-frame detector and wake control of the serial receiver.
// Assumes the receive pin is asynchronous; sleep state, enables and frame end come
// from same-clock logic.
`timescale 1ns/1ns

// Summary of operation
// - A recognised start bit wakes the device from Power-down and Standby.
// - A falling receive edge powers the 8MHz oscillator and enables the serial clock.
// - Detection works in both asynchronous and synchronous receive modes.
// - Detection acts only while the start-detection enable is set.
// - With start interrupts enabled, a start raises the receive-start interrupt at once.
// - Without start interrupts, oscillator and serial clock run only for the frame.
// - Other clocks stay stopped until receive-complete wakes the processor.
// - In asynchronous mode from Idle the receiver keeps its active-mode maximum rate.
// - In asynchronous mode a start bit is confirmed by a majority of the middle samples, two highs reject it.
module usfw_top (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       serial_receive_input,
    input  wire logic       start_detect_enable,
    input  wire logic       start_interrupt_enable,
    input  wire logic       sync_mode,
    input  wire logic       double_speed,
    input  wire logic [1:0] sleep_state,
    input  wire logic       osc_ready,
    input  wire logic       sample_tick,
    input  wire logic       frame_done,
    output logic            osc_enable,
    output logic            serial_clk_enable,
    output logic            other_clk_enable,
    output logic            start_irq,
    output logic            wake_cpu,
    output logic            start_valid
);
    usfw_sample_if smp ();
    usfw_pkg::usfw_state_t state_reg;

    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    logic fall;
    logic deep_sleep;
    logic idle_sleep;
    logic active_run;
    logic keep_clocks;
    logic edge_taken;
    logic vote_pass;
    logic sync_start;

    // --------------------------------------------------------------
    // Pin synchroniser and edge detect
    // --------------------------------------------------------------
    // Two flops before use; only the second stage feeds the edge detector.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_receive_input;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    assign fall       = rx_prev_reg && !rx_sync_reg;
    assign deep_sleep = (sleep_state == usfw_pkg::USFW_SLEEP_STANDBY)
                     || (sleep_state == usfw_pkg::USFW_SLEEP_PWRDOWN);
    assign idle_sleep = (sleep_state == usfw_pkg::USFW_SLEEP_IDLE);

    // --------------------------------------------------------------
    // Vote hookup
    // --------------------------------------------------------------
    // Synchronous mode takes the edge as the start; the vote only runs asynchronously.
    assign smp.restart      = (state_reg == usfw_pkg::USFW_WAKE) && osc_ready && !sync_mode;
    assign smp.sample_tick  = sample_tick && (state_reg == usfw_pkg::USFW_CONFIRM);
    assign smp.line         = rx_sync_reg;
    assign smp.double_speed = double_speed;

    usfw_vote u_vote (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .smp     (smp)
    );

    // --------------------------------------------------------------
    // Detector state machine
    // --------------------------------------------------------------
    // Edges with detection disabled are ignored entirely.
    // A taken edge reaches the wake state two to three cycles after the pin falls: the
    // two synchroniser flops lie in between and the previous-value flop adds none. In asynchronous mode a low pulse
    // shorter than the vote window never reaches the frame state, and edges that arrive
    // while a frame is in hand are not looked at until the state is idle again.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= usfw_pkg::USFW_IDLE;
        end else begin
            case (state_reg)
                usfw_pkg::USFW_IDLE: begin
                    if (fall && start_detect_enable) begin
                        state_reg <= usfw_pkg::USFW_WAKE;
                    end
                end
                usfw_pkg::USFW_WAKE: begin
                    // Wait for the oscillator; the far side's baud covers this.
                    if (!start_detect_enable) begin
                        state_reg <= usfw_pkg::USFW_IDLE;
                    end else if (osc_ready) begin
                        state_reg <= sync_mode ? usfw_pkg::USFW_FRAME
                                               : usfw_pkg::USFW_CONFIRM;
                    end
                end
                usfw_pkg::USFW_CONFIRM: begin
                    if (!start_detect_enable) begin
                        state_reg <= usfw_pkg::USFW_IDLE;
                    end else if (smp.done) begin
                        state_reg <= smp.reject ? usfw_pkg::USFW_IDLE
                                                : usfw_pkg::USFW_FRAME;
                    end
                end
                usfw_pkg::USFW_FRAME: begin
                    if (frame_done || !start_detect_enable) begin
                        state_reg <= usfw_pkg::USFW_IDLE;
                    end
                end
                default: begin
                    state_reg <= usfw_pkg::USFW_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Request terms shared by the output flops
    // --------------------------------------------------------------
    // Only Standby and Power-down gate the clocks; in active operation and in Idle the
    // block leaves them running, so an Idle wake keeps the active-mode rate.
    assign active_run  = (sleep_state == usfw_pkg::USFW_SLEEP_ACTIVE);
    assign keep_clocks = active_run || idle_sleep;

    // An edge is taken only from the idle state and only with detection enabled.
    assign edge_taken  = (state_reg == usfw_pkg::USFW_IDLE) && fall && start_detect_enable;

    // A start is confirmed by a passing vote, or at once in synchronous mode, where the
    // edge itself marks the start and there is nothing to vote on.
    assign vote_pass   = (state_reg == usfw_pkg::USFW_CONFIRM) && smp.done && !smp.reject
                      && start_detect_enable;
    assign sync_start  = (state_reg == usfw_pkg::USFW_WAKE) && osc_ready && sync_mode
                      && start_detect_enable;

    // --------------------------------------------------------------
    // Clock requests
    // --------------------------------------------------------------
    // The oscillator is requested on the taken edge itself, rising on the same clock as the state
    // change, because its start-up time is the longest delay in the wake path.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_enable <= 1'b0;
        end else begin
            osc_enable <= keep_clocks
                       || (state_reg != usfw_pkg::USFW_IDLE)
                       || edge_taken;
        end
    end

    // The serial clock follows the same request, so the receiver never runs from a
    // stopped oscillator and never keeps it alive after the frame.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            serial_clk_enable <= 1'b0;
        end else begin
            serial_clk_enable <= keep_clocks
                              || (state_reg != usfw_pkg::USFW_IDLE)
                              || edge_taken;
        end
    end

    // --------------------------------------------------------------
    // Interrupt, confirmation and wake
    // --------------------------------------------------------------
    // The start interrupt is a one-cycle pulse on the taken edge; it does not wait for
    // the vote, so a noise spike can still raise it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_irq <= 1'b0;
        end else begin
            start_irq <= edge_taken && start_interrupt_enable;
        end
    end

    // One-cycle start confirmation for the neighbouring frame logic.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_valid <= 1'b0;
        end else begin
            start_valid <= vote_pass || sync_start;
        end
    end

    // The core is woken at the start when the start interrupt is on, and in every case by
    // receive completion at the end of the frame; both only from deep sleep.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_cpu <= 1'b0;
        end else begin
            wake_cpu <= deep_sleep
                     && ((edge_taken && start_interrupt_enable)
                         || ((state_reg == usfw_pkg::USFW_FRAME) && frame_done
                             && start_detect_enable));
        end
    end

    // Every other clock stays stopped through a deep-sleep reception; it returns only
    // when the woken core leaves deep sleep.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            other_clk_enable <= 1'b1;
        end else begin
            other_clk_enable <= !deep_sleep;
        end
    end
endmodule

//--- design/usfw_pkg.sv
// Package of the start-of-frame wake block: states, sleep codes and sample figures.
// Assumes a single 100 MHz system clock; nothing here is synthesised on its own.
package usfw_pkg;

    // ------------------------------------------------------------------
    // Detector states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        USFW_IDLE    = 4'h1,
        USFW_WAKE    = 4'h2,
        USFW_CONFIRM = 4'h4,
        USFW_FRAME   = 4'h8
    } usfw_state_t;

    // ------------------------------------------------------------------
    // Sleep state codes
    // ------------------------------------------------------------------
    localparam logic [1:0] USFW_SLEEP_ACTIVE  = 2'h0;
    localparam logic [1:0] USFW_SLEEP_IDLE    = 2'h1;
    localparam logic [1:0] USFW_SLEEP_STANDBY = 2'h2;
    localparam logic [1:0] USFW_SLEEP_PWRDOWN = 2'h3;

    // ------------------------------------------------------------------
    // Start-bit vote: samples 8, 9, 10 (normal) or 4, 5, 6 (double speed)
    // ------------------------------------------------------------------
    localparam logic [4:0] USFW_VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] USFW_VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] USFW_VOTE_SPAN         = 5'h02;
    localparam logic [4:0] USFW_SAMPLE_ONE        = 5'h01;
    localparam logic [1:0] USFW_VOTE_REJECT       = 2'h2;

endpackage

//--- design/usfw_sample_if.sv
// Interface carrying the sample strobe and synchronised line to the vote module.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface usfw_sample_if;
    logic       restart;
    logic       sample_tick;
    logic       line;
    logic       double_speed;
    logic       done;
    logic       reject;

    modport ctrl (output restart, output sample_tick, output line, output double_speed,
                  input done, input reject);
    modport vote (input restart, input sample_tick, input line, input double_speed,
                  output done, output reject);
endinterface

//--- design/usfw_vote.sv
// Start-bit majority vote over three middle samples of the start bit.
// Assumes the caller pulses restart once the oscillator is ready, which counts as sample 1.
`timescale 1ns/1ns
module usfw_vote (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    usfw_sample_if.vote smp
);
    logic [4:0] count_reg;
    logic [1:0] highs_reg;
    logic [4:0] first;

    assign first = smp.double_speed ? usfw_pkg::USFW_VOTE_FIRST_DOUBLE
                                    : usfw_pkg::USFW_VOTE_FIRST_NORMAL;

    // --------------------------------------------------------------
    // Sample counter and high count
    // --------------------------------------------------------------
    // Sample numbering and high-level tally inside the voting window.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 5'h00;
            highs_reg <= 2'h0;
            smp.done  <= 1'b0;
            smp.reject <= 1'b0;
        end else if (smp.restart) begin
            count_reg <= usfw_pkg::USFW_SAMPLE_ONE;
            highs_reg <= 2'h0;
            smp.done  <= 1'b0;
            smp.reject <= 1'b0;
        end else if (smp.sample_tick && !smp.done) begin
            count_reg <= count_reg + 5'h01;
            if (count_reg + 5'h01 >= first && count_reg + 5'h01 <= first + usfw_pkg::USFW_VOTE_SPAN
                && smp.line) begin
                highs_reg <= highs_reg + 2'h1;
            end
            if (count_reg + 5'h01 == first + usfw_pkg::USFW_VOTE_SPAN) begin
                smp.done <= 1'b1;
                // Two or more highs mean a noise spike.
                smp.reject <= ((highs_reg + {1'b0, smp.line}) >= usfw_pkg::USFW_VOTE_REJECT);
            end
        end else begin
            smp.done <= 1'b0;
        end
    end
endmodule

//--- verif/usfw_sva.sv
// Checker of the start-of-frame wake block; it watches the top-level ports only.
// Assumes a bind from the bench and the single clk_sys domain with reset_n.
`timescale 1ns/1ns
module usfw_sva (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       serial_receive_input,
    input wire logic       start_detect_enable,
    input wire logic       start_interrupt_enable,
    input wire logic       sync_mode,
    input wire logic [1:0] sleep_state,
    input wire logic       osc_ready,
    input wire logic       frame_done,
    input wire logic       osc_enable,
    input wire logic       serial_clk_enable,
    input wire logic       other_clk_enable,
    input wire logic       start_irq,
    input wire logic       wake_cpu,
    input wire logic       start_valid
);
    // ----------
    // Properties
    // ----------
    // The past terms keep the first edge after reset release from judging reset values.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_irq_gate: assert property (
        start_irq |-> start_detect_enable && start_interrupt_enable)
        else $error("start interrupt without enables");
    a_irq_clocks: assert property (start_irq |-> osc_enable && serial_clk_enable)
        else $error("start interrupt before clocks run");
    a_irq_pulse: assert property (start_irq |=> !start_irq)
        else $error("start interrupt longer than one cycle");
    a_clk_pair: assert property (osc_enable == serial_clk_enable)
        else $error("oscillator and serial clock disagree");
    a_osc_on_fall: assert property (
        $rose(osc_enable) && $past(reset_n) && $past(sleep_state[1])
        |-> start_detect_enable && !$past(serial_receive_input, 2))
        else $error("oscillator woke without an enabled falling edge");
    a_done_drop: assert property (frame_done && sleep_state[1] |=> ##[0:1] !osc_enable)
        else $error("clocks kept after the frame in deep sleep");
    a_other_stop: assert property (
        $past(reset_n) && $stable(sleep_state) |-> other_clk_enable == !sleep_state[1])
        else $error("other clocks wrong for sleep state");
    a_wake_deep: assert property (wake_cpu |-> sleep_state[1])
        else $error("wake request outside deep sleep");
    a_valid_run: assert property (
        start_valid |-> osc_enable && osc_ready && start_detect_enable)
        else $error("start confirmed without a running clock");
    c_deep_irq: cover property (start_irq && wake_cpu);
    c_sync_ok: cover property (start_valid && sync_mode);
    c_deep_done: cover property (frame_done && sleep_state[1]);
endmodule

//--- verif/usfw_remote_tx.sv
// Remote sender model: drives the receive line with a start bit of given length.
// Assumes the bench pulses send for one cycle while the line is idle.
`timescale 1ns/1ns
module usfw_remote_tx (
    input  wire logic       clk_sys,
    input  wire logic       send,
    input  wire logic [7:0] low_len,
    output logic            line
);
    logic [7:0] cnt_reg = 8'h00;

    // The start bit is held long and the rest sent as marks, so the frame after the
    // start only matters once the oscillator runs; the rate stays far below any limit.
    // The line moves just after the rising edge, so send, driven on the falling edge,
    // is never sampled in the same time step in which the bench changes it.
    always_ff @(posedge clk_sys) begin
        if (send) cnt_reg <= low_len;
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    end
    assign line = (cnt_reg == 8'h00);
endmodule

//--- verif/tb_uart_start_frame_wake.sv
// Bench of the start-of-frame wake block: frames in, expected pulses noted in a queue.
// Assumes the design, its checker and the sender model are compiled before it.
`timescale 1ns/1ns
module tb_uart_start_frame_wake;
    logic        clk_sys, reset_n, serial_receive_input, start_detect_enable;
    logic        start_interrupt_enable, sync_mode, double_speed, osc_ready;
    logic        sample_tick, frame_done, send, osc_enable, serial_clk_enable;
    logic        other_clk_enable, start_irq, wake_cpu, start_valid, deep, ok;
    logic [1:0]  sleep_state;
    logic [7:0]  low_len, osc_dly, osc_cnt;
    logic [31:0] rnd;
    logic [2:0]  exp_q[$];
    int          bad_count, check_count, i, n;

    usfw_top u_usfw_top (.clk_sys, .reset_n, .serial_receive_input, .start_detect_enable,
        .start_interrupt_enable, .sync_mode, .double_speed, .sleep_state, .osc_ready,
        .sample_tick, .frame_done, .osc_enable, .serial_clk_enable, .other_clk_enable,
        .start_irq, .wake_cpu, .start_valid);
    usfw_remote_tx u_usfw_remote_tx (.clk_sys, .send, .low_len, .line(serial_receive_input));

    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Sample strobe every second cycle; the oscillator needs osc_dly cycles to start.
    always @(negedge clk_sys) begin
        sample_tick <= ~sample_tick;
        // The start-up count saturates, so osc_ready never drops while the oscillator runs.
        osc_cnt     <= !osc_enable ? 8'h00 : (osc_cnt == 8'hFF) ? osc_cnt : osc_cnt + 8'h01;
        osc_ready   <= osc_enable && (osc_cnt >= osc_dly);
    end

    // Each pulse seen is matched with the oldest note; a pulse with no note is wrong.
    always @(negedge clk_sys) begin
        if (reset_n && (start_irq | start_valid | wake_cpu) === 1'b1) begin
            chk({wake_cpu, start_valid, start_irq},
                exp_q.size() == 0 ? 3'b000 : exp_q.pop_front());
        end
    end

    // ----------
    // Main sequence: every sleep code, both modes and both vote speeds.
    // ----------
    initial begin
        {reset_n, send, frame_done, sample_tick, osc_ready} = 5'h00;
        {start_detect_enable, start_interrupt_enable, sync_mode, double_speed} = 4'h0;
        sleep_state = 2'h0;
        {osc_dly, osc_cnt, low_len} = 24'h000000;
        rnd = 32'h34CC;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        for (i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            {double_speed, sync_mode, sleep_state} = i[3:0];
            start_interrupt_enable = rnd[0];
            start_detect_enable = (i % 5 != 4);
            osc_dly = {5'h00, rnd[3:1]};
            ok = start_detect_enable && (sync_mode || rnd[4]);
            deep = sleep_state[1];
            low_len = (sync_mode || rnd[4]) ? 8'h50 : 8'h06;
            repeat (4) @(negedge clk_sys);
            if (start_detect_enable && start_interrupt_enable) exp_q.push_back({deep, 2'b01});
            if (ok) exp_q.push_back(3'b010);
            send = 1'b1;
            @(negedge clk_sys);
            send = 1'b0;
            for (n = 0; n < 150 && start_valid !== 1'b1; n++) @(negedge clk_sys);
            if (ok) begin
                if (n == 150) begin
                    bad_count++;
                    test_done();
                end
                repeat (100) @(negedge clk_sys);
                if (deep) exp_q.push_back(3'b100);
                frame_done = 1'b1;
                @(negedge clk_sys);
                frame_done = 1'b0;
            end
            repeat (6) @(negedge clk_sys);
            chk({osc_enable, serial_clk_enable, other_clk_enable}, {3{!deep}});
        end
        chk({2'b00, exp_q.size() == 0}, 3'b001);
        test_done();
    end
endmodule

bind usfw_top usfw_sva u_usfw_sva (.clk_sys, .reset_n, .serial_receive_input,
    .start_detect_enable, .start_interrupt_enable, .sync_mode, .sleep_state, .osc_ready,
    .frame_done, .osc_enable, .serial_clk_enable, .other_clk_enable, .start_irq,
    .wake_cpu, .start_valid);
